// ===== design/sta_pkg.sv
// constants, register map and rate table of the serial teleprinter adapter
package sta_pkg;

  // =====================================================================
  // clocking and oversampling
  localparam int unsigned CLK_HZ      = 25_000_000;  // sys_clk rate
  localparam int unsigned OVERSAMPLE  = 16;          // ticks per bit time
  localparam logic [3:0]  OS_LAST     = 4'hf;        // last tick of a bit
  localparam logic [3:0]  OS_MID      = 4'h7;        // mid-bit tick of start bit
  localparam logic [3:0]  FRAME_BITS  = 4'hb;        // start, 8 data, 2 stop
  localparam logic [3:0]  DATA_BITS   = 4'h8;
  localparam int unsigned FRAME_TICKS = 176;         // frame bits times oversample
  localparam int unsigned RATE_COUNT  = 12;
  localparam logic [3:0]  RATE_DEFAULT = 4'hb;       // 9600 bit/s
  localparam logic        MARK        = 1'b1;
  localparam logic        SPACE       = 1'b0;

  typedef logic [7:0] sta_byte_t;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ADDR_TXDATA  = 8'h00;
  localparam logic [7:0] ADDR_RXDATA  = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_INTSTAT = 8'h10;
  localparam logic [7:0] ADDR_INTMASK = 8'h14;
  localparam logic [7:0] ADDR_DIAG    = 8'h18;

  // control fields
  localparam int unsigned CTRL_RATE_LO = 0;
  localparam int unsigned CTRL_RATE_HI = 3;
  localparam int unsigned CTRL_INVERT  = 4;
  localparam int unsigned CTRL_BOOTSRC = 5;
  localparam logic [5:0]  CTRL_RESET   = 6'h0b;
  localparam int unsigned DIAG_WRAP    = 0;

  // status bits
  localparam int unsigned ST_RXFULL = 0;
  localparam int unsigned ST_TXBUSY = 1;
  localparam int unsigned ST_WRAP   = 2;
  localparam int unsigned ST_BOOT   = 3;
  localparam int unsigned ST_CSPEND = 4;
  localparam int unsigned ST_RXBUSY = 5;

  // event bits of interrupt status and mask
  localparam int unsigned EV_RX    = 0;
  localparam int unsigned EV_TX    = 1;
  localparam int unsigned EV_WRAP  = 2;
  localparam int unsigned EV_FRAME = 3;
  localparam int unsigned EV_OVER  = 4;
  localparam int unsigned EV_W     = 5;

  // bit rate for each rate selection of the control register
  function automatic int unsigned sta_bit_rate(input logic [3:0] sel);
    case (sel)
      4'h0:    return 50;
      4'h1:    return 75;
      4'h2:    return 100;
      4'h3:    return 110;
      4'h4:    return 150;
      4'h5:    return 200;
      4'h6:    return 300;
      4'h7:    return 600;
      4'h8:    return 1200;
      4'h9:    return 2400;
      4'ha:    return 4800;
      default: return 9600;
    endcase
  endfunction

endpackage

// ===== design/sta_tx.sv
// transmit serialiser: one 11-bit start-stop frame per byte
`timescale 1ns/1ns
`default_nettype none
module sta_tx (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // oversample enable
  input  wire logic              tick16,
  // byte to send
  input  wire logic              txStart,
  input  wire sta_pkg::sta_byte_t txByte,
  // line side, mark is one
  output logic                   txMark,
  output logic                   txBusy,
  output logic                   txDone
);
  import sta_pkg::*;

  logic [10:0] frame_reg;
  logic [3:0]  bitCnt_reg;
  logic [3:0]  osCnt_reg;
  logic [7:0]  byteHold_reg;
  logic [7:0]  tickCnt_reg;

  // =====================================================================
  // frame shifter, low bit on the line first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_reg  <= '1;
      bitCnt_reg <= '0;
      osCnt_reg  <= '0;
      txBusy     <= 1'b0;
      txDone     <= 1'b0;
    end else begin
      txDone <= 1'b0;
      if (txStart && !txBusy) begin
        frame_reg  <= {MARK, MARK, txByte, SPACE};  // see [R3] see [R14]
        bitCnt_reg <= '0;
        osCnt_reg  <= '0;
        txBusy     <= 1'b1;
      end else if (txBusy && tick16) begin
        osCnt_reg <= osCnt_reg + 4'h1;
        if (osCnt_reg == OS_LAST) begin
          frame_reg  <= {MARK, frame_reg[10:1]};  // see [R2]
          bitCnt_reg <= bitCnt_reg + 4'h1;
          if (bitCnt_reg == FRAME_BITS - 4'h1) begin
            txBusy <= 1'b0;
            txDone <= 1'b1;
          end
        end
      end
    end
  end

  assign txMark = frame_reg[0];

  // =====================================================================
  // helper state for the checks below
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byteHold_reg <= '0;
      tickCnt_reg  <= '0;
    end else if (txStart && !txBusy) begin
      byteHold_reg <= txByte;
      tickCnt_reg  <= '0;
    end else if (txBusy && tick16) begin
      tickCnt_reg <= tickCnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  frame_len_a: assert property (txDone |-> tickCnt_reg == 8'(FRAME_TICKS)) // see [R3]
    else $error("frame not eleven bit times long");
  lsb_first_a: assert property (txBusy && bitCnt_reg >= 4'h1 && bitCnt_reg <= DATA_BITS // see [R2]
    |-> txMark == byteHold_reg[3'(bitCnt_reg - 4'h1)])
    else $error("data bit out of order on line");
  idle_mark_a: assert property (!txBusy |-> txMark == MARK) // see [R14]
    else $error("line not at mark while idle");
endmodule
`default_nettype wire

// ===== design/sta_rx.sv
// receive deserialiser: start edge hunt, mid-bit confirm, centre sampling
`timescale 1ns/1ns
`default_nettype none
module sta_rx (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // oversample enable and synchronised line, mark is one
  input  wire logic              tick16,
  input  wire logic              lineMark,
  // received byte
  output sta_pkg::sta_byte_t     rxByte,
  output logic                   rxValid,
  output logic                   rxFrameErr,
  output logic                   rxBusy
);
  import sta_pkg::*;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} sta_rx_e;

  sta_rx_e    state_reg;
  logic [3:0] osCnt_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;

  // =====================================================================
  // receive sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= RX_HUNT;
      osCnt_reg  <= '0;
      bitCnt_reg <= '0;
      shift_reg  <= '0;
      rxByte     <= '0;
      rxValid    <= 1'b0;
      rxFrameErr <= 1'b0;
    end else begin
      rxValid    <= 1'b0;
      rxFrameErr <= 1'b0;
      if (tick16) begin
        osCnt_reg <= osCnt_reg + 4'h1;
        unique case (state_reg)
          RX_HUNT: begin
            osCnt_reg <= '0;
            if (lineMark == SPACE) state_reg <= RX_START;  // see [R15]
          end
          RX_START: begin
            if (osCnt_reg == OS_MID) begin
              osCnt_reg  <= '0;
              bitCnt_reg <= '0;
              state_reg  <= (lineMark == SPACE) ? RX_DATA : RX_HUNT;  // see [R15]
            end
          end
          RX_DATA: begin
            if (osCnt_reg == OS_LAST) begin
              shift_reg  <= {lineMark, shift_reg[7:1]};  // see [R2]
              bitCnt_reg <= bitCnt_reg + 4'h1;
              if (bitCnt_reg == DATA_BITS - 4'h1) state_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            // hunting resumes at the centre of the first stop bit, so one or two are taken
            if (osCnt_reg == OS_LAST) begin
              state_reg <= RX_HUNT;  // see [R13]
              if (lineMark == MARK) begin
                rxByte  <= shift_reg;  // see [R6] see [R7]
                rxValid <= 1'b1;
              end else begin
                rxFrameErr <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  assign rxBusy = (state_reg != RX_HUNT);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  start_confirm_a: assert property (state_reg == RX_START && tick16 && osCnt_reg == OS_MID // see [R15]
    && lineMark == MARK |=> state_reg == RX_HUNT)
    else $error("false start bit not rejected");
endmodule
`default_nettype wire

// ===== design/sta_top.sv
// serial teleprinter adapter: register port, rate divider, wrap, boot load, interrupts
//
// Operation
// [R1] transmit and receive run independently so a byte can go out while another comes in.
// [R2] each byte goes on the line lowest bit first and highest bit last.
// [R3] every byte travels in its own start-stop frame eleven bit times long.
// [R4] the bit rate is a static selection from 50 to 9600 bit/s in twelve steps.
// [R5] a configuration bit chooses which line level is mark, for both directions.
// [R6] all 256 byte values pass unchanged both ways.
// [R7] no parity is made or checked and no byte is treated as a control character.
// [R8] normally the processor moves one byte per programmed_io_command, read or write.
// [R9] as a boot_load source, received bytes go one by one into memory by cycle steal.
// [R10] a diagnostic command sets the wrap state, which then stays for later transfers.
// [R11] in wrap, a write sends its byte out and also loads it into the receive register.
// [R12] after a wrapped write an interrupt is raised so a read can check the byte.
// [R13] the receiver takes frames with one stop bit; otherwise the device sends two.
// [R14] a frame is one space start bit, eight data bits and two mark stop bits; idle is mark.
// [R15] the receiver finds the start edge, confirms it mid-bit and samples each bit centre.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sta_top #(
  parameter int unsigned CLK_HZ_P = sta_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [7:0]        regAddr,
  input  wire sta_pkg::sta_byte_t regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output sta_pkg::sta_byte_t     regRdata,
  // serial line
  input  wire logic              rxPin,
  output logic                   txPin,
  // boot_load cycle steal
  input  wire logic              bootLoad,
  output logic                   csReq,
  output logic [15:0]            csAddr,
  output sta_pkg::sta_byte_t     csData,
  input  wire logic              csAck,
  // interrupt
  output logic                   irq
);
  import sta_pkg::*;

  logic [5:0]      ctrl_reg;
  logic            wrapState_reg;
  logic [EV_W-1:0] intStat_reg;
  logic [EV_W-1:0] intMask_reg;
  sta_byte_t       rxData_reg;
  logic            rxFull_reg;
  logic [15:0]     divCnt_reg;
  logic            tick16_reg;
  logic            rxS1_reg;
  logic            rxS2_reg;
  logic            rxS3_reg;
  logic            rxLevel_reg;
  logic            bootLoadDly_reg;
  logic [15:0]     divTab [RATE_COUNT];
  logic [3:0]      rateSel;
  logic            invert;
  logic            bootActive;
  logic            txWrite;
  logic            txStart;
  logic            wrapLoad;
  logic            lineLoad;
  logic            bootByte;
  logic            rxRead;
  logic            txMark;
  logic            txBusy;
  logic            txDone;
  sta_byte_t       rxByte;
  logic            rxValid;
  logic            rxFrameErr;
  logic            rxBusy;
  logic [EV_W-1:0] events;
  sta_byte_t       statusVal;

  // =====================================================================
  // rate divider: one tick per sixteenth of a bit time
  for (genvar g = 0; g < RATE_COUNT; g++) begin : g_div
    assign divTab[g] = 16'(CLK_HZ_P / (sta_bit_rate(4'(g)) * OVERSAMPLE));  // see [R4]
  end

  // selection out of range falls back to the default rate
  assign rateSel = (ctrl_reg[CTRL_RATE_HI:CTRL_RATE_LO] < 4'(RATE_COUNT)) ?
                   ctrl_reg[CTRL_RATE_HI:CTRL_RATE_LO] : RATE_DEFAULT;
  assign invert  = ctrl_reg[CTRL_INVERT];

  // divider counter and tick pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_reg <= '0;
      tick16_reg <= 1'b0;
    end else if (divCnt_reg >= divTab[rateSel] - 16'h0001) begin
      divCnt_reg <= '0;
      tick16_reg <= 1'b1;  // see [R4]
    end else begin
      divCnt_reg <= divCnt_reg + 16'h0001;
      tick16_reg <= 1'b0;
    end
  end

  // =====================================================================
  // line side: three-stage receive synchroniser and polarity
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxS1_reg    <= MARK;
      rxS2_reg    <= MARK;
      rxS3_reg    <= MARK;
      rxLevel_reg <= MARK;
    end else begin
      rxS1_reg <= rxPin;
      rxS2_reg <= rxS1_reg;
      rxS3_reg <= rxS2_reg;
      if (rxS2_reg == rxS3_reg) rxLevel_reg <= rxS3_reg;  // change counts once two agree
    end
  end

  // transmit pin with selected polarity
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) txPin <= MARK;
    else         txPin <= txMark ^ invert;  // see [R5]
  end

  // =====================================================================
  // independent transmit and receive engines
  sta_tx u_tx (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick16  (tick16_reg),
    .txStart (txStart),
    .txByte  (regWdata),
    .txMark  (txMark),
    .txBusy  (txBusy),
    .txDone  (txDone)
  );

  sta_rx u_rx (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .tick16     (tick16_reg),
    .lineMark   (rxLevel_reg ^ invert),  // see [R5]
    .rxByte     (rxByte),
    .rxValid    (rxValid),
    .rxFrameErr (rxFrameErr),
    .rxBusy     (rxBusy)
  );

  // =====================================================================
  // command decode
  assign txWrite    = regWr && (regAddr == ADDR_TXDATA);
  assign txStart    = txWrite && !txBusy;  // see [R1] see [R8]
  assign wrapLoad   = txStart && wrapState_reg;  // see [R11]
  assign bootActive = bootLoad && ctrl_reg[CTRL_BOOTSRC];
  assign bootByte   = rxValid && bootActive;  // see [R9]
  assign lineLoad   = rxValid && !bootActive && !wrapState_reg;
  assign rxRead     = regRd && (regAddr == ADDR_RXDATA);

  // control register and wrap state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg      <= CTRL_RESET;
      wrapState_reg <= 1'b0;
    end else if (regWr) begin
      if (regAddr == ADDR_CTRL) ctrl_reg <= regWdata[5:0];
      if (regAddr == ADDR_DIAG) wrapState_reg <= regWdata[DIAG_WRAP];  // see [R10]
    end
  end

  // =====================================================================
  // receive data register, loaded from line or from a wrapped write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxData_reg <= '0;
      rxFull_reg <= 1'b0;
    end else if (wrapLoad) begin
      rxData_reg <= regWdata;  // see [R11]
      rxFull_reg <= 1'b1;
    end else if (lineLoad) begin
      rxData_reg <= rxByte;  // see [R6] see [R7]
      rxFull_reg <= 1'b1;
    end else if (rxRead) begin
      rxFull_reg <= 1'b0;  // see [R8]
    end
  end

  // =====================================================================
  // boot_load cycle steal: one request per received byte that finds no unacknowledged steal pending
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      csReq           <= 1'b0;
      csAddr          <= '0;
      csData          <= '0;
      bootLoadDly_reg <= 1'b0;
    end else begin
      bootLoadDly_reg <= bootLoad;
      if (bootLoad && !bootLoadDly_reg) begin
        csAddr <= '0;  // new load starts at the bottom of memory
      end else if (csReq && csAck) begin
        csAddr <= csAddr + 16'h0001;
      end
      // a byte that meets the ack of the previous steal is still taken
      if (bootByte && (!csReq || csAck)) begin
        csReq  <= 1'b1;  // see [R9]
        csData <= rxByte;
      end else if (csAck) begin
        csReq <= 1'b0;
      end
    end
  end

  // =====================================================================
  // interrupt status, set wins over write-one-to-clear
  always_comb begin
    events           = '0;
    events[EV_RX]    = lineLoad;
    events[EV_TX]    = txDone;
    events[EV_WRAP]  = wrapLoad;  // see [R12]
    events[EV_FRAME] = rxFrameErr;
    events[EV_OVER]  = ((lineLoad || wrapLoad) && rxFull_reg && !rxRead) ||
                       (bootByte && csReq && !csAck);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intStat_reg <= '0;
      intMask_reg <= '0;
    end else begin
      if (regWr && regAddr == ADDR_INTSTAT) intStat_reg <= (intStat_reg & ~regWdata[EV_W-1:0]) | events;
      else                                  intStat_reg <= intStat_reg | events;
      if (regWr && regAddr == ADDR_INTMASK) intMask_reg <= regWdata[EV_W-1:0];
    end
  end

  assign irq = |(intStat_reg & intMask_reg);  // see [R12]

  // =====================================================================
  // read port, data valid the cycle after the strobe
  always_comb begin
    statusVal            = '0;
    statusVal[ST_RXFULL] = rxFull_reg;
    statusVal[ST_TXBUSY] = txBusy;
    statusVal[ST_WRAP]   = wrapState_reg;
    statusVal[ST_BOOT]   = bootActive;
    statusVal[ST_CSPEND] = csReq;
    statusVal[ST_RXBUSY] = rxBusy;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_RXDATA:  regRdata <= rxData_reg;  // see [R8]
        ADDR_CTRL:    regRdata <= {2'h0, ctrl_reg};
        ADDR_STATUS:  regRdata <= statusVal;
        ADDR_INTSTAT: regRdata <= {3'h0, intStat_reg};
        ADDR_INTMASK: regRdata <= {3'h0, intMask_reg};
        ADDR_DIAG:    regRdata <= {7'h00, wrapState_reg};
        default:      regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wrap_hold_a: assert property (wrapState_reg && !(regWr && regAddr == ADDR_DIAG) |=> wrapState_reg) // see [R10]
    else $error("wrap state lost without command");
  wrap_loop_a: assert property (wrapLoad |=> rxFull_reg && rxData_reg == $past(regWdata) && txBusy) // see [R11]
    else $error("wrapped byte not looped back");
  wrap_irq_a: assert property (wrapLoad |=> intStat_reg[EV_WRAP] && (!intMask_reg[EV_WRAP] || irq)) // see [R12]
    else $error("wrapped write raised no interrupt");
  read_data_a: assert property (rxRead |=> regRdata == $past(rxData_reg) // see [R8]
    ##1 ($past(regRd) || regRdata == 8'h00))
    else $error("read data wrong or held too long");
  boot_steal_a: assert property (bootByte && !csReq |=> csReq && csData == $past(rxByte)) // see [R9]
    else $error("boot byte not stolen to memory");
  duplex_a: assert property (txStart && rxBusy |=> txBusy) // see [R1]
    else $error("transmit blocked by receive");
  polarity_a: assert property ($stable(invert) && !$past(txBusy) && !txBusy |-> txPin == (MARK ^ invert)) // see [R5]
    else $error("idle line level wrong for polarity");

  wrap_cover_c: cover property (wrapLoad ##[1:4] rxRead);
  boot_cover_c: cover property (csReq && csAck);
  ferr_cover_c: cover property (rxFrameErr);
  txirq_cover_c: cover property (txDone && intMask_reg[EV_TX] ##1 irq);
endmodule
`default_nettype wire

// ===== tb/sta_term_model.sv
// serial terminal model: sends frames into the adapter and decodes what it transmits
`timescale 1ns/1ns
`default_nettype none
module sta_term_model (
  // clock and line setup
  input  wire logic        sys_clk,
  input  wire logic [15:0] bitCyc,
  input  wire logic        invert,
  // serial lines
  input  wire logic        txPin,
  output logic             rxPin
);
  logic       lvl = 1'b1;
  logic       mark;
  logic [7:0] sh;
  logic [7:0] gotByte;
  logic       gotStop;

  // line level follows the selected polarity, idle at mark
  assign rxPin = lvl ^ invert;
  assign mark  = txPin ^ invert;

  // =====================================================================
  // send one frame: space start, data lowest bit first, mark stop bits
  task automatic send(input logic [7:0] b, input int stops);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int k = 0; k < 9 + stops; k++) begin
      lvl <= f[k];
      repeat (bitCyc) @(posedge sys_clk);
    end
    lvl <= 1'b1;
  endtask

  // decode frames from the transmit pin, sampling bit centres
  always begin
    @(negedge mark);
    repeat (bitCyc / 2) @(posedge sys_clk);
    if (mark === 1'b0) begin
      for (int k = 0; k < 8; k++) begin
        repeat (bitCyc) @(posedge sys_clk);
        sh[k] = mark;
      end
      repeat (bitCyc) @(posedge sys_clk);
      gotStop = mark;
      repeat (bitCyc) @(posedge sys_clk);
      gotStop = gotStop & mark;
      gotByte = sh;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking testbench of the serial teleprinter adapter
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sta_pkg::*;
  logic        sys_clk, resetn, regWr, regRd, rxPin, txPin;
  logic        bootLoad, csReq, csAck, irq, inv;
  logic [7:0]  regAddr;
  sta_byte_t   regWdata, regRdata, csData;
  logic [15:0] csAddr, bitCyc;
  int          err_total, n_checks;

  // design and far-side terminal
  sta_top #(.CLK_HZ_P(1536000)) i_sta_top (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxPin(rxPin),
    .txPin(txPin), .bootLoad(bootLoad), .csReq(csReq), .csAddr(csAddr), .csData(csData),
    .csAck(csAck), .irq(irq));
  sta_term_model i_sta_term_model (.sys_clk(sys_clk), .bitCyc(bitCyc), .invert(inv),
    .txPin(txPin), .rxPin(rxPin));

  always #20 sys_clk = ~sys_clk;

  // =====================================================================
  // bus and compare helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // read strobe for one cycle, data taken in the cycle after
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(n, e, regRdata);
    @(posedge sys_clk);
  endtask

  // byte out and byte in at the same time, then check both and clear events
  task automatic xfer(input logic [7:0] t, input logic [7:0] r, input int stops);
    fork
      i_sta_term_model.send(r, stops);
      wr(ADDR_TXDATA, t);
    join
    repeat (bitCyc * 2) @(posedge sys_clk);
    chk("txByte", t, i_sta_term_model.gotByte);
    chk("txStop", 1, i_sta_term_model.gotStop);
    chk("irq", 1, irq);
    rc(ADDR_RXDATA, r, "rxByte");
    wr(ADDR_INTSTAT, 8'hff);
    chk("irqClr", 0, irq);
  endtask

  task automatic steal(input logic [7:0] b, input logic [15:0] a);
    for (int i = 0; i < 4000 && csReq !== 1'b1; i++) @(posedge sys_clk);
    chk("csReq", 1, csReq);
    chk("csData", b, csData);
    chk("csAddr", a, csAddr);
    csAck <= 1'b1;
    @(posedge sys_clk);
    csAck <= 1'b0;
    @(posedge sys_clk);
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset();
    chk("idle", 1, txPin);
    chk("irqRst", 0, irq);
    rc(ADDR_CTRL, {2'b00, CTRL_RESET}, "ctrlRst");
    rc(8'h1c, 8'h00, "unmapped");
  endtask

  task automatic t_duplex();
    wr(ADDR_INTMASK, 8'h03);
    xfer(8'ha5, 8'h3c, 1);
  endtask

  task automatic t_invert();
    wr(ADDR_CTRL, 8'h1b);
    inv <= 1'b1;
    repeat (200) @(posedge sys_clk);
    xfer(8'h96, 8'hc3, 2);
    chk("idleInv", 0, txPin);
    wr(ADDR_CTRL, 8'h0b);
    inv <= 1'b0;
    repeat (200) @(posedge sys_clk);
  endtask

  task automatic t_rate();
    wr(ADDR_CTRL, 8'h0a);
    bitCyc <= 16'd320;
    repeat (400) @(posedge sys_clk);
    xfer(8'h17, 8'h69, 1);
    wr(ADDR_CTRL, 8'h0b);
    bitCyc <= 16'd160;
    repeat (400) @(posedge sys_clk);
  endtask

  task automatic t_wrap();
    logic [7:0] b;
    wr(ADDR_INTMASK, 8'h04);
    wr(ADDR_DIAG, 8'h01);
    for (int i = 0; i < 2; i++) begin
      b = i ? 8'hff : 8'h00;
      wr(ADDR_TXDATA, b);
      chk("wrapIrq", 1, irq);
      rc(ADDR_STATUS, 8'h07, "wrapSt");
      rc(ADDR_RXDATA, b, "wrapRx");
      wr(ADDR_INTSTAT, 8'hff);
      repeat (bitCyc * 12) @(posedge sys_clk);
      chk("wrapTx", b, i_sta_term_model.gotByte);
    end
    // second wrapped byte with the first unread: overwrite and overrun
    wr(ADDR_TXDATA, 8'h5a);
    repeat (bitCyc * 12) @(posedge sys_clk);
    wr(ADDR_TXDATA, 8'h5b);
    rc(ADDR_INTSTAT, 8'h16, "overrun");
    rc(ADDR_RXDATA, 8'h5b, "overRx");
    repeat (bitCyc * 12) @(posedge sys_clk);
    wr(ADDR_INTSTAT, 8'hff);
    wr(ADDR_DIAG, 8'h00);
  endtask

  task automatic t_boot();
    wr(ADDR_CTRL, 8'h2b);
    bootLoad <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fork
      begin
        i_sta_term_model.send(8'h81, 1);
        i_sta_term_model.send(8'h42, 1);
      end
      begin
        steal(8'h81, 16'h0000);
        steal(8'h42, 16'h0001);
      end
    join
    rc(ADDR_INTSTAT, 8'h00, "bootEv");
    bootLoad <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // =====================================================================
  // main sequence and watchdog
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    bootLoad = 1'b0;
    csAck = 1'b0;
    inv = 1'b0;
    bitCyc = 16'd160;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_duplex();
    t_invert();
    t_rate();
    t_wrap();
    t_boot();
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
